/* File: include/pxb_pkg.sv */
// constants shared by the bridge split-capability register block
package pxb_pkg;

   // ==========================================================
   // register offsets in each bridge function's config space
   localparam logic [7:0] OFS_BRIDGE_STATUS = 8'hA4;
   localparam logic [7:0] OFS_UP_SPLIT = 8'hA8;

   // ==========================================================
   // bridge status register layout
   localparam logic [31:0] BSTAT_RESET = 32'h0003_0000;
   localparam int BIT_SPLIT_REQUEST_DELAYED = 21;
   localparam int BIT_SPLIT_OVERRUN = 20;
   localparam int BIT_UNEXPECTED_SPLIT = 19;
   localparam int BIT_SPLIT_DISCARDED = 18;
   localparam int BIT_DEV64 = 17;
   localparam int BIT_UNDESCRIBED16 = 16;
   localparam int DEVNUM_LSB = 3;
   localparam int DEVNUM_W = 5;
   localparam int FUNCNUM_LSB = 0;
   localparam logic [2:0] FUNC_NUMBER = 3'h0;

   // ==========================================================
   // upstream split transaction register layout
   localparam int LIMIT_LSB = 16;
   localparam int HALF_W = 16;
   localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
   localparam logic [15:0] LIMIT_NO_LIMIT = 16'hFFFF;
   localparam int BE_LIMIT_LO = 2;
   localparam int BE_LIMIT_HI = 3;

   // ==========================================================
   // bridge function indices
   localparam int NUM_BRIDGES = 2;
   localparam logic [4:0] SECOND_BRIDGE_STEP = 5'h01;

endpackage

/* File: rtl/pxb_bridge_regs.sv */
// register pair of one bridge function: bridge status and upstream split
`timescale 1ns/1ps
module pxb_bridge_regs #(
   parameter int FUNC_INDEX = 0,
   parameter logic [15:0] CAPACITY = 16'h0010
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // identity from the link configuration
   input wire logic [4:0] link_unit_identifier,
   // write access, already decoded to this function
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   // read data, combinational
   output logic [31:0] rdata
);

   // ==========================================================
   // elaboration check: only two bridge functions exist, and the
   // device-number offset below assumes index 0 or 1
   if (FUNC_INDEX < 0 || FUNC_INDEX >= pxb_pkg::NUM_BRIDGES) begin : g_bad_index
      $error("bridge function index out of range");
   end

   // ==========================================================
   // storage: only the commitment limit is writable
   logic [15:0] limit_reg;
   logic [15:0] limit_next;
   wire logic hit_split = (addr == pxb_pkg::OFS_UP_SPLIT);
   wire logic hit_status = (addr == pxb_pkg::OFS_BRIDGE_STATUS);
   wire logic wr_split = wr_en & hit_split;

   // byte lanes 2 and 3 update the limit, lanes 0 and 1 are dropped
   always_comb begin
      limit_next = limit_reg;
      if (wr_split & be[pxb_pkg::BE_LIMIT_LO]) begin
         limit_next[7:0] = wdata[23:16];
      end
      if (wr_split & be[pxb_pkg::BE_LIMIT_HI]) begin
         limit_next[15:8] = wdata[31:24];
      end
   end

   // reset leaves the limit at all ones, which means unlimited
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         limit_reg <= pxb_pkg::LIMIT_RESET;
      end else begin
         limit_reg <= limit_next;
      end
   end

   // ==========================================================
   // bridge status: device number follows the link id, second is +1
   wire logic [4:0] dev_number = (FUNC_INDEX == 0) ? link_unit_identifier :
      5'(link_unit_identifier + pxb_pkg::SECOND_BRIDGE_STEP);
   logic [31:0] status_word;

   // start from the reset image so bits 17 and 16 stay high and the
   // error bits stay low; status writes land nowhere
   always_comb begin
      status_word = pxb_pkg::BSTAT_RESET;
      status_word[pxb_pkg::BIT_SPLIT_REQUEST_DELAYED] = 1'b0;
      status_word[pxb_pkg::BIT_SPLIT_OVERRUN] = 1'b0;
      status_word[pxb_pkg::BIT_UNEXPECTED_SPLIT] = 1'b0;
      status_word[pxb_pkg::BIT_SPLIT_DISCARDED] = 1'b0;
      status_word[pxb_pkg::BIT_DEV64] = 1'b1;
      status_word[pxb_pkg::DEVNUM_LSB +: pxb_pkg::DEVNUM_W] = dev_number;
      status_word[pxb_pkg::FUNCNUM_LSB +: 3] = pxb_pkg::FUNC_NUMBER;
   end

   // read mux; the low half of the split register is fixed capacity
   assign rdata = hit_status ? status_word :
      hit_split ? {limit_reg, CAPACITY} : '0;

endmodule // pxb_bridge_regs

/* File: rtl/pxb_split_regs.sv */
// split-capability registers and buffer credit gates of two bridges
`timescale 1ns/1ps
module pxb_split_regs #(
   parameter logic [15:0] DN_RESP_CAPACITY = 16'h0010,
   parameter logic [15:0] UP_RESP_BUFS = 16'h0010
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // link identity, from the same clock domain
   input wire logic [4:0] LINK_UNIT_IDENTIFIER,
   // configuration access port
   input wire logic CFG_RD,
   input wire logic CFG_WR,
   input wire logic CFG_SEL,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [3:0] CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   output logic CFG_ACK,
   output logic [31:0] CFG_RDATA,
   // upstream link read requests against downstream buffers
   input wire logic [1:0] UP_RD_REQ,
   input wire logic [1:0] DN_BUF_FREE,
   output logic [1:0] UP_RD_GRANT,
   // downstream bus read requests against upstream buffers
   input wire logic [1:0] DN_RD_REQ,
   input wire logic [1:0] UP_BUF_FREE,
   output logic [1:0] DN_RD_GRANT
);

   // ==========================================================
   // elaboration checks
   if (DN_RESP_CAPACITY == '0) begin : g_bad_dn
      $error("downstream response capacity must be nonzero");
   end
   if (UP_RESP_BUFS == '0) begin : g_bad_up
      $error("upstream response buffer count must be nonzero");
   end

   // ==========================================================
   // credit arithmetic shared by every pool
   // a pool never climbs past its size, so a stray free cannot
   // mint a credit that has no buffer behind it
   function automatic logic [15:0] credit_next(
      input logic [15:0] cnt,
      input logic take,
      input logic give,
      input logic [15:0] size
   );
      logic [15:0] val;
      val = cnt;
      if (take && !give) begin
         val = 16'(cnt - 16'h0001);
      end else if (give && !take && cnt != size) begin
         val = 16'(cnt + 16'h0001);
      end
      return val;
   endfunction

   // ==========================================================
   // register pairs, one per bridge function
   logic [31:0] rdata_w [pxb_pkg::NUM_BRIDGES];
   logic [1:0] wr_sel;

   // writes reach only the selected function
   assign wr_sel[0] = CFG_WR & ~CFG_SEL;
   assign wr_sel[1] = CFG_WR & CFG_SEL;

   for (genvar g = 0; g < pxb_pkg::NUM_BRIDGES; g++) begin : g_fn
      pxb_bridge_regs #(
         .FUNC_INDEX(g),
         .CAPACITY(DN_RESP_CAPACITY)
      ) u_regs (
         .clock(CLOCK),
         .resetn(RESETN),
         .link_unit_identifier(LINK_UNIT_IDENTIFIER),
         .wr_en(wr_sel[g]),
         .addr(CFG_ADDR),
         .be(CFG_BE),
         .wdata(CFG_WDATA),
         .rdata(rdata_w[g])
      );
   end

   // ==========================================================
   // configuration answer
   wire logic [31:0] rd_sel = CFG_SEL ? rdata_w[1] : rdata_w[0];
   wire logic access = CFG_RD | CFG_WR;
   logic ack_reg;
   logic [31:0] rdata_reg;
   wire logic [31:0] rdata_next = CFG_RD ? rd_sel : rdata_reg;

   // read data is captured before any same-cycle write lands,
   // so a combined access returns the old value
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= access;
         rdata_reg <= rdata_next;
      end
   end

   assign CFG_ACK = ack_reg;
   assign CFG_RDATA = rdata_reg;

   // ==========================================================
   // buffer credit gates, per bridge
   // the commitment limit is deliberately not consulted here: the
   // only cap is the real free-buffer count
   logic [15:0] dn_cnt_reg [pxb_pkg::NUM_BRIDGES];
   logic [15:0] up_cnt_reg [pxb_pkg::NUM_BRIDGES];
   logic [1:0] up_grant_reg;
   logic [1:0] dn_grant_reg;
   logic [1:0] up_grant_next;
   logic [1:0] dn_grant_next;

   for (genvar b = 0; b < pxb_pkg::NUM_BRIDGES; b++) begin : g_cr
      wire logic dn_avail = (dn_cnt_reg[b] != '0);
      wire logic up_avail = (up_cnt_reg[b] != '0);
      wire logic [15:0] dn_next;
      wire logic [15:0] up_next;

      // grant only while a buffer is free
      assign up_grant_next[b] = UP_RD_REQ[b] & dn_avail;
      assign dn_grant_next[b] = DN_RD_REQ[b] & up_avail;
      assign dn_next = credit_next(dn_cnt_reg[b], up_grant_next[b],
         DN_BUF_FREE[b], DN_RESP_CAPACITY);
      assign up_next = credit_next(up_cnt_reg[b], dn_grant_next[b],
         UP_BUF_FREE[b], UP_RESP_BUFS);

      // pools start full after reset
      always_ff @(posedge CLOCK or negedge RESETN) begin
         if (!RESETN) begin
            dn_cnt_reg[b] <= DN_RESP_CAPACITY;
            up_cnt_reg[b] <= UP_RESP_BUFS;
         end else begin
            dn_cnt_reg[b] <= dn_next;
            up_cnt_reg[b] <= up_next;
         end
      end
   end

   // grants last one cycle per credit taken, registered for clean outputs
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         up_grant_reg <= '0;
         dn_grant_reg <= '0;
      end else begin
         up_grant_reg <= up_grant_next;
         dn_grant_reg <= dn_grant_next;
      end
   end

   assign UP_RD_GRANT = up_grant_reg;
   assign DN_RD_GRANT = dn_grant_reg;

endmodule // pxb_split_regs

/* File: tb/pxb_split_props.sv */
// concurrent checks on the ports of the split-capability register block
`timescale 1ns/1ps
module pxb_split_props #(
   parameter logic [15:0] DN_RESP_CAPACITY = 16'h0010
) (
   // clock, reset and identity
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [4:0] LINK_UNIT_IDENTIFIER,
   // configuration reads
   input wire logic CFG_RD,
   input wire logic CFG_SEL,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [31:0] CFG_RDATA,
   // credit gates
   input wire logic [1:0] UP_RD_REQ,
   input wire logic [1:0] UP_RD_GRANT,
   input wire logic [1:0] DN_RD_REQ,
   input wire logic [1:0] DN_RD_GRANT
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // ==========================================================
   // read answers: data lands one edge after the read is taken
   sequence s_rd_stat; CFG_RD && CFG_ADDR == 8'hA4; endsequence
   sequence s_rd_split; CFG_RD && CFG_ADDR == 8'hA8; endsequence
   property p_srd; s_rd_stat |=> !CFG_RDATA[21]; endproperty
   a_srd: assert property (p_srd) else $error("bit 21 set");
   property p_sco; s_rd_stat |=> !CFG_RDATA[20]; endproperty
   a_sco: assert property (p_sco) else $error("bit 20 set");
   property p_usc; s_rd_stat |=> !CFG_RDATA[19]; endproperty
   a_usc: assert property (p_usc) else $error("bit 19 set");
   property p_scd; s_rd_stat |=> !CFG_RDATA[18]; endproperty
   a_scd: assert property (p_scd) else $error("bit 18 set");
   property p_dev64; s_rd_stat |=> CFG_RDATA[17]; endproperty
   a_dev64: assert property (p_dev64) else $error("bit 17 clear");
   // second function reports the identifier plus one, wrapping at 31
   property p_devnum;
      s_rd_stat |=> CFG_RDATA[7:3] == 5'($past(LINK_UNIT_IDENTIFIER) + {4'h0, $past(CFG_SEL)});
   endproperty
   a_devnum: assert property (p_devnum) else $error("device number wrong");
   property p_func; s_rd_stat |=> CFG_RDATA[2:0] == 3'h0; endproperty
   a_func: assert property (p_func) else $error("function number wrong");
   property p_rsvd; s_rd_stat |=> CFG_RDATA[31:22] == 10'h000; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_b16; s_rd_stat |=> CFG_RDATA[16] && CFG_RDATA[15:8] == 8'h00; endproperty
   a_b16: assert property (p_b16) else $error("bits 16 to 8 wrong");
   property p_cap; s_rd_split |=> CFG_RDATA[15:0] == DN_RESP_CAPACITY; endproperty
   a_cap: assert property (p_cap) else $error("capacity wrong");
   // a grant never appears without a request taken on the edge before
   property p_dn_gnt; (DN_RD_GRANT & ~$past(DN_RD_REQ)) == 2'h0; endproperty
   a_dn_gnt: assert property (p_dn_gnt) else $error("downstream grant unasked");
   property p_up_gnt; (UP_RD_GRANT & ~$past(UP_RD_REQ)) == 2'h0; endproperty
   a_up_gnt: assert property (p_up_gnt) else $error("upstream grant unasked");
endmodule // pxb_split_props
bind pxb_split_regs pxb_split_props #(.DN_RESP_CAPACITY(DN_RESP_CAPACITY)) u_props (
   .CLOCK(CLOCK), .RESETN(RESETN), .LINK_UNIT_IDENTIFIER(LINK_UNIT_IDENTIFIER),
   .CFG_RD(CFG_RD), .CFG_SEL(CFG_SEL), .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA),
   .UP_RD_REQ(UP_RD_REQ), .UP_RD_GRANT(UP_RD_GRANT), .DN_RD_REQ(DN_RD_REQ),
   .DN_RD_GRANT(DN_RD_GRANT));

/* File: tb/testbench.sv */
// self-checking bench for the split-capability register block
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic rd = 1'b0, wr = 1'b0, sel = 1'b0, ack;
   logic [4:0] id = 5'h00;
   logic [4:0] ids [3] = '{5'h00, 5'h1F, 5'h0A};
   logic [7:0] addr = 8'h00;
   logic [3:0] be = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] up_req = 2'h0, dn_free = 2'h0, up_gnt, dn_req = 2'h0, up_free = 2'h0, dn_gnt;
   int n_mismatch = 0, n_checks = 0, cycles = 0;
   // small pools so exhaustion shows within a few requests
   pxb_split_regs #(.DN_RESP_CAPACITY(16'h0002), .UP_RESP_BUFS(16'h0002)) uut (
      .CLOCK(clock), .RESETN(resetn), .LINK_UNIT_IDENTIFIER(id), .CFG_RD(rd), .CFG_WR(wr),
      .CFG_SEL(sel), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_ACK(ack),
      .CFG_RDATA(rdata), .UP_RD_REQ(up_req), .DN_BUF_FREE(dn_free), .UP_RD_GRANT(up_gnt),
      .DN_RD_REQ(dn_req), .UP_BUF_FREE(up_free), .DN_RD_GRANT(dn_gnt));
   initial begin
      forever #2 clock = ~clock;
   end
   // ==========================================================
   // run control: a hang is cut short far beyond the expected length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // one access: request stands for one edge, acknowledge follows it
   task automatic acc(input logic r, input logic s, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      @(posedge clock);
      rd <= r;
      wr <= ~r;
      sel <= s;
      addr <= a;
      be <= b;
      wdata <= d;
      @(posedge clock);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
      check({31'h0, ack}, 32'h1);
   endtask
   task automatic rdv(input logic s, input logic [7:0] a, input logic [31:0] exp);
      acc(1'b1, s, a, 4'h0, 32'h0);
      check(rdata, exp);
   endtask
   // hold a request over four edges and count the grants returned
   task automatic credit(input int b, input logic up, input logic [31:0] exp);
      logic [31:0] n;
      n = 32'h0;
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         if (up) up_req[b] <= (i < 4);
         else dn_req[b] <= (i < 4);
         #1;
         n = n + (up ? up_gnt[b] : dn_gnt[b]);
      end
      check(n, exp);
   endtask
   // release one buffer back to the pool that feeds the chosen gate
   task automatic give(input int b, input logic up);
      @(posedge clock);
      if (up) dn_free[b] <= 1'b1;
      else up_free[b] <= 1'b1;
      @(posedge clock);
      dn_free[b] <= 1'b0;
      up_free[b] <= 1'b0;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      foreach (ids[k]) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            id <= ids[k];
            rdv(1'(s), 8'hA4, 32'h0003_0000 | {24'h0, 5'(ids[k] + 5'(s)), 3'h0});
         end
      end
      acc(1'b0, 1'b0, 8'hA4, 4'hF, 32'hFFFF_FFFF);
      rdv(1'b0, 8'hA4, 32'h0003_0050);
      rdv(1'b0, 8'hA8, 32'hFFFF_0002);
      acc(1'b0, 1'b0, 8'hA8, 4'hF, 32'h1234_5678);
      rdv(1'b0, 8'hA8, 32'h1234_0002);
      acc(1'b0, 1'b0, 8'hA8, 4'h4, 32'h00CD_0000);
      rdv(1'b0, 8'hA8, 32'h12CD_0002);
      rdv(1'b1, 8'hA8, 32'hFFFF_0002);
      rdv(1'b0, 8'hA0, 32'h0000_0000);
      // the lowest limit software may set is the capacity; the gates must ignore it
      acc(1'b0, 1'b0, 8'hA8, 4'hF, 32'h0002_0000);
      rdv(1'b0, 8'hA8, 32'h0002_0002);
      for (int b = 0; b < 2; b++) begin
         for (int u = 0; u < 2; u++) begin
            give(b, 1'(u));
            credit(b, 1'(u), 32'h2);
            give(b, 1'(u));
            credit(b, 1'(u), 32'h1);
         end
      end
      // hand the limit back at its no-limit default, as software should leave it
      acc(1'b0, 1'b0, 8'hA8, 4'hC, 32'hFFFF_0000);
      rdv(1'b0, 8'hA8, 32'hFFFF_0002);
      finish_test();
   end
endmodule // testbench
